// [core/tcms_chan_sel.sv]
// One channel: clock selection, edge detection and trigger generation
`timescale 1ns/1ps
module tcms_chan_sel
    import tcms_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Mode fields
    input  wire logic [7:0] mode_high,
    input  wire logic [7:0] mode_low,
    // Events
    input  wire logic       ck_a_en,
    input  wire logic       ck_b_en,
    input  wire logic       pin_in,
    input  wire logic       master_irq,
    // Results
    output logic            op_clk_en_q,
    output logic            count_clk_en_q,
    output logic            start_trig_q,
    output logic            capture_trig_q
);

    logic pin_q;
    logic op_en;
    logic rise;
    logic fall;
    logic valid_edge;
    logic [2:0] trig;
    logic [1:0] edge_sel;

    assign trig     = mode_high[TCMS_TRIG_MSB -: 3];
    assign edge_sel = mode_low[TCMS_EDGE_MSB -: 2];
    assign op_en    = mode_high[TCMS_OPCLK_BIT] ? ck_b_en : ck_a_en;
    assign rise     = op_en && pin_in && !pin_q;
    assign fall     = op_en && !pin_in && pin_q;

    // Pin sampled only on the operation clock, so edges narrower than it are lost
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pin_q <= 1'b0;
        else if (op_en)
            pin_q <= pin_in;
    end

    always_comb
    begin
        unique case (edge_sel)
            TCMS_EDGE_FALL: valid_edge = fall;
            TCMS_EDGE_RISE: valid_edge = rise;
            default:        valid_edge = rise || fall;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            op_clk_en_q    <= 1'b0;
            count_clk_en_q <= 1'b0;
        end
        else
        begin
            op_clk_en_q    <= op_en;
            count_clk_en_q <= mode_high[TCMS_CCS_BIT] ? valid_edge : op_en;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            start_trig_q   <= 1'b0;
            capture_trig_q <= 1'b0;
        end
        else
        begin
            start_trig_q   <= 1'b0;
            capture_trig_q <= 1'b0;
            if (trig == TCMS_TRIG_EDGE)
            begin
                start_trig_q   <= valid_edge;
                capture_trig_q <= valid_edge;
            end
            else if (trig == TCMS_TRIG_BOTH)
            begin
                // Low width: fall starts, rise captures; high width swapped
                start_trig_q   <= (edge_sel == TCMS_EDGE_HIGH) ? rise : fall;
                capture_trig_q <= (edge_sel == TCMS_EDGE_HIGH) ? fall : rise;
            end
            else if (trig == TCMS_TRIG_MASTER)
                start_trig_q <= master_irq;
        end
    end

    AST_TRIG_SW_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        (trig == TCMS_TRIG_SW) ##1 (trig == TCMS_TRIG_SW) |-> !start_trig_q && !capture_trig_q)
        else $error("Trigger fired with software-only source");

    AST_MASTER_START: assert property (@(posedge mclk) disable iff (!rst_n)
        (trig == TCMS_TRIG_MASTER) && master_irq |=> start_trig_q)
        else $error("Master interrupt did not start slave");

endmodule : tcms_chan_sel

// [core/tcms_pkg.sv]
// Package: register map, field layout and codes for the timer channel mode select block
package tcms_pkg;

    // Register byte addresses
    localparam logic [19:0] TCMS_ADDR_CH0_LOW  = 20'hf0190;
    localparam logic [19:0] TCMS_ADDR_CH0_HIGH = 20'hf0191;
    localparam logic [19:0] TCMS_ADDR_CH1_LOW  = 20'hf0192;
    localparam logic [19:0] TCMS_ADDR_CH1_HIGH = 20'hf0193;
    localparam logic [19:0] TCMS_ADDR_RUNNING  = 20'hf0194;
    localparam logic [19:0] TCMS_ADDR_STATUS   = 20'hf0195;

    // Reset values
    localparam logic [7:0] TCMS_MODE_RESET = 8'h00;

    // High-half field positions
    localparam int TCMS_OPCLK_BIT  = 7;
    localparam int TCMS_CCS_BIT    = 4;
    localparam int TCMS_SPLIT_BIT  = 3;
    localparam int TCMS_TRIG_MSB   = 2;

    // Low-half field positions
    localparam int TCMS_EDGE_MSB   = 7;
    localparam int TCMS_MODE_MSB   = 3;
    localparam int TCMS_MODE_LSB   = 1;
    localparam int TCMS_STIRQ_BIT  = 0;

    // Writable bit masks (unassigned bits stay zero)
    localparam logic [7:0] TCMS_HIGH_MASK_CH0 = 8'h97;
    localparam logic [7:0] TCMS_HIGH_MASK_CH1 = 8'h9f;
    localparam logic [7:0] TCMS_LOW_MASK      = 8'hcf;

    // Trigger source codes
    localparam logic [2:0] TCMS_TRIG_SW     = 3'h0;
    localparam logic [2:0] TCMS_TRIG_EDGE   = 3'h1;
    localparam logic [2:0] TCMS_TRIG_BOTH   = 3'h2;
    localparam logic [2:0] TCMS_TRIG_MASTER = 3'h4;

    // Edge codes
    localparam logic [1:0] TCMS_EDGE_FALL = 2'h0;
    localparam logic [1:0] TCMS_EDGE_RISE = 2'h1;
    localparam logic [1:0] TCMS_EDGE_LOW  = 2'h2;
    localparam logic [1:0] TCMS_EDGE_HIGH = 2'h3;

    // Channel mode codes
    localparam logic [2:0] TCMS_MD_INTERVAL = 3'h0;
    localparam logic [2:0] TCMS_MD_CAPTURE  = 3'h2;
    localparam logic [2:0] TCMS_MD_EVENT    = 3'h3;
    localparam logic [2:0] TCMS_MD_ONECNT   = 3'h4;
    localparam logic [2:0] TCMS_MD_CAPONE   = 3'h6;

    // Bus answer states
    typedef enum logic [1:0] {
        TCMS_BUS_IDLE = 2'b01,
        TCMS_BUS_ACK  = 2'b10
    } tcms_bus_state_t;

endpackage : tcms_pkg

// [core/tcms_top.sv]
// Top: mode registers for two timer channels behind an Avalon-MM slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module tcms_top
    import tcms_pkg::*;
#(
    parameter int NCH = 2
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [19:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_writedata,
    output logic [7:0]       avs_readdata,
    output logic             avs_waitrequest,
    // Prescaled clock enables
    input  wire logic        prescaled_clock_a,
    input  wire logic        prescaled_clock_b,
    // Timer input pins
    input  wire logic [1:0]  timer_input_pin,
    // Channel state from counter datapath
    input  wire logic [1:0]  chan_running_flag,
    input  wire logic [1:0]  chan_counting,
    input  wire logic [1:0]  chan_start_bit,
    input  wire logic [1:0]  chan_interrupt,
    // Selected clocks and triggers
    output logic [1:0]       chan_op_clock,
    output logic [1:0]       chan_count_clock,
    output logic [1:0]       chan_start_trig,
    output logic [1:0]       chan_capture_trig,
    // Decoded mode
    output logic             half_width_select,
    output logic [5:0]       chan_mode_onehot,
    output logic [1:0]       chan_down_count,
    output logic [1:0]       chan_start_irq,
    output logic [1:0]       chan_restart,
    output logic [1:0]       chan_bad_mode
);

    tcms_bus_state_t bus_q;
    logic [7:0] low_q  [NCH];
    logic [7:0] high_q [NCH];
    logic [1:0] op_en_w;
    logic [1:0] cnt_en_w;
    logic [1:0] st_w;
    logic [1:0] cap_w;
    logic       wr_go;
    logic [7:0] rd_d;

    function automatic logic [2:0] mode_of(input logic [7:0] low);
        mode_of = low[TCMS_MODE_MSB:TCMS_MODE_LSB];
    endfunction : mode_of

    function automatic logic mode_legal(input logic [2:0] md);
        mode_legal = (md == TCMS_MD_INTERVAL) || (md == TCMS_MD_CAPTURE) || (md == TCMS_MD_EVENT)
                  || (md == TCMS_MD_ONECNT) || (md == TCMS_MD_CAPONE);
    endfunction : mode_legal

    function automatic logic trig_legal(input logic [2:0] tr);
        trig_legal = (tr == TCMS_TRIG_SW) || (tr == TCMS_TRIG_EDGE) || (tr == TCMS_TRIG_BOTH)
                  || (tr == TCMS_TRIG_MASTER);
    endfunction : trig_legal

    // One wait cycle: every access answers on its second edge
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            bus_q <= TCMS_BUS_IDLE;
        else
        begin
            unique case (bus_q)
                TCMS_BUS_IDLE: if (avs_read || avs_write) bus_q <= TCMS_BUS_ACK;
                TCMS_BUS_ACK:  bus_q <= TCMS_BUS_IDLE;
                default:       bus_q <= TCMS_BUS_IDLE;
            endcase
        end
    end

    assign wr_go = avs_write && (bus_q == TCMS_BUS_ACK);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && (bus_q == TCMS_BUS_IDLE));
    end

    // Writes ignore running state: the guard is software's duty, hardware takes the value
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                low_q[i]  <= TCMS_MODE_RESET;
                high_q[i] <= TCMS_MODE_RESET;
            end
        end
        else if (wr_go)
        begin
            unique case (avs_address)
                TCMS_ADDR_CH0_LOW:  low_q[0]  <= avs_writedata & TCMS_LOW_MASK;
                TCMS_ADDR_CH0_HIGH: high_q[0] <= avs_writedata & TCMS_HIGH_MASK_CH0;
                TCMS_ADDR_CH1_LOW:  low_q[1]  <= avs_writedata & TCMS_LOW_MASK;
                TCMS_ADDR_CH1_HIGH: high_q[1] <= avs_writedata & TCMS_HIGH_MASK_CH1;
                default:            ;
            endcase
        end
    end

    always_comb
    begin
        unique case (avs_address)
            TCMS_ADDR_CH0_LOW:  rd_d = low_q[0];
            TCMS_ADDR_CH0_HIGH: rd_d = high_q[0];
            TCMS_ADDR_CH1_LOW:  rd_d = low_q[1];
            TCMS_ADDR_CH1_HIGH: rd_d = high_q[1];
            TCMS_ADDR_RUNNING:  rd_d = {6'h00, chan_running_flag};
            TCMS_ADDR_STATUS:   rd_d = {4'h0, chan_bad_mode, chan_count_clock};
            default:            rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            avs_readdata <= 8'h00;
        else if (avs_read && (bus_q == TCMS_BUS_IDLE))
            avs_readdata <= rd_d;
    end

    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        tcms_chan_sel u_sel (
            .mclk           (mclk),
            .rst_n          (rst_n),
            .mode_high      (high_q[c]),
            .mode_low       (low_q[c]),
            .ck_a_en        (prescaled_clock_a),
            .ck_b_en        (prescaled_clock_b),
            .pin_in         (timer_input_pin[c]),
            .master_irq     (chan_interrupt[0]),
            .op_clk_en_q    (op_en_w[c]),
            .count_clk_en_q (cnt_en_w[c]),
            .start_trig_q   (st_w[c]),
            .capture_trig_q (cap_w[c])
        );
    end

    assign chan_op_clock     = op_en_w;
    assign chan_count_clock  = cnt_en_w;
    assign chan_start_trig   = st_w;
    assign chan_capture_trig = cap_w;

    // Mode decode registered so every output leaves from a flip-flop
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            half_width_select <= 1'b0;
            chan_mode_onehot  <= 6'h00;
            chan_down_count   <= 2'h0;
            chan_start_irq    <= 2'h0;
            chan_restart      <= 2'h0;
            chan_bad_mode     <= 2'h0;
        end
        else
        begin
            half_width_select <= high_q[1][TCMS_SPLIT_BIT];
            for (int i = 0; i < NCH; i++)
            begin
                chan_mode_onehot[3*i +: 3] <= mode_of(low_q[i]);
                chan_down_count[i] <= (mode_of(low_q[i]) == TCMS_MD_INTERVAL) || (mode_of(low_q[i]) == TCMS_MD_EVENT)
                    || (mode_of(low_q[i]) == TCMS_MD_ONECNT);
                chan_start_irq[i]  <= low_q[i][TCMS_STIRQ_BIT]
                    && ((mode_of(low_q[i]) == TCMS_MD_INTERVAL) || (mode_of(low_q[i]) == TCMS_MD_CAPTURE));
                chan_restart[i]    <= low_q[i][TCMS_STIRQ_BIT] && (mode_of(low_q[i]) == TCMS_MD_ONECNT)
                    && chan_counting[i] && (chan_start_bit[i] || st_w[i]);
                chan_bad_mode[i]   <= !mode_legal(mode_of(low_q[i]))
                    || !trig_legal(high_q[i][TCMS_TRIG_MSB -: 3]);
            end
        end
    end

    AST_CH0_SPLIT_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        !high_q[0][TCMS_SPLIT_BIT])
        else $error("Channel 0 split bit set");

    AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_go && (avs_address == TCMS_ADDR_CH1_LOW) |=> low_q[1] == ($past(avs_writedata) & TCMS_LOW_MASK))
        else $error("Low half write lost");

    AST_SPLIT_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 half_width_select == $past(high_q[1][TCMS_SPLIT_BIT]))
        else $error("Split output wrong");

    AST_START_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
        chan_start_irq[0] |-> $past(low_q[0][TCMS_STIRQ_BIT]))
        else $error("Start interrupt without option");

    AST_RESET_CLEAR: assert property (@(posedge mclk)
        !rst_n |=> (low_q[0] == TCMS_MODE_RESET) && (high_q[1] == TCMS_MODE_RESET))
        else $error("Mode not cleared by reset");

    AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest && (bus_q == TCMS_BUS_IDLE) |=> !avs_waitrequest)
        else $error("Bus answer late");

endmodule : tcms_top

// [verification/tcms_far_model.sv]
// Far-side model: prescaler enables, timer input pins, master interrupt
`timescale 1ns/1ps
module tcms_far_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Activity control
    input  wire logic       clk_on,
    input  wire logic       pin_on,
    // Far-side outputs
    output logic            clk_a,
    output logic            clk_b,
    output logic [1:0]      pin,
    output logic            irq
);
    logic [2:0] div_q;
    logic [3:0] hold_q;

    // Rates never change while channels run
    always_ff @(posedge mclk)
        div_q <= (!rst_n || div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
    assign clk_a = clk_on && !div_q[0];
    assign clk_b = clk_on && (div_q == 3'h0 || div_q == 3'h3);

    // Pin held six cycles at least, so slow clock still samples each level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pin <= 2'h0;
        else if (pin_on && hold_q == 4'h0)
            pin <= pin ^ 2'($urandom_range(1, 3));
        if (!rst_n || (pin_on && hold_q == 4'h0))
            hold_q <= 4'($urandom_range(6, 9));
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
        irq <= rst_n && pin_on && !irq && $urandom_range(3) == 0;
    end
endmodule : tcms_far_model

// [verification/tcms_top_test.sv]
// Testbench: register access, mode decode, clock and trigger selection
`timescale 1ns/1ps
module tcms_top_test;
    import tcms_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [19:0] adr = 20'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  wd = 8'h0;
    logic [7:0]  rdata;
    logic        wait_r;
    logic        clk_a, clk_b, irq, split;
    logic        clk_on = 1'b0;
    logic        pin_on = 1'b0;
    logic        win = 1'b0;
    logic [1:0]  run = 2'h0;
    logic [1:0]  cnting = 2'h0;
    logic [1:0]  sw_st = 2'h0;
    logic [1:0]  pin, pin_d, op_clk, cnt_clk, st_trig, cp_trig, down, stirq, restart, bad;
    logic [5:0]  md;
    logic [14:0] ev;
    logic [15:0] cnt[15];
    logic [7:0]  mk[4] = '{TCMS_LOW_MASK, TCMS_HIGH_MASK_CH0, TCMS_LOW_MASK, TCMS_HIGH_MASK_CH1};
    logic [2:0]  tt[4] = '{TCMS_TRIG_SW, TCMS_TRIG_EDGE, TCMS_TRIG_BOTH, TCMS_TRIG_MASTER};
    int          error_cnt = 0;
    int          checked = 0;

    tcms_top i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_r), .prescaled_clock_a(clk_a),
        .prescaled_clock_b(clk_b), .timer_input_pin(pin), .chan_running_flag(run), .chan_counting(cnting),
        .chan_start_bit(sw_st), .chan_interrupt({1'b0, irq}), .chan_op_clock(op_clk),
        .chan_count_clock(cnt_clk), .chan_start_trig(st_trig), .chan_capture_trig(cp_trig),
        .half_width_select(split), .chan_mode_onehot(md), .chan_down_count(down), .chan_start_irq(stirq),
        .chan_restart(restart), .chan_bad_mode(bad));
    tcms_far_model i_far (.mclk(mclk), .rst_n(rst_n), .clk_on(clk_on), .pin_on(pin_on), .clk_a(clk_a),
        .clk_b(clk_b), .pin(pin), .irq(irq));

    always #4 mclk = ~mclk;

    // Event counters, cleared outside the window
    assign ev = {cp_trig, st_trig, cnt_clk, op_clk, ~pin & pin_d, pin & ~pin_d, irq, clk_b, clk_a};
    always @(posedge mclk)
    begin
        pin_d <= pin;
        for (int k = 0; k < 15; k++)
            cnt[k] <= win ? cnt[k] + 16'(ev[k]) : 16'h0;
    end

    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_cnt(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_cnt

    // One access; extra edge at the end keeps back-to-back calls clean
    task automatic bus(input logic w, input logic [19:0] a, input logic [7:0] d, output logic [7:0] q);
        int k;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (wait_r !== 1'b0 && k < 100);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 100)
        begin
            error_cnt++;
            print_verdict();
        end
        @(posedge mclk);
    endtask : bus

    function automatic logic [3:0] dec(input logic [7:0] lo, input logic go);
        logic [2:0] m;
        m = lo[3:1];
        return {m inside {3'h0, 3'h3, 3'h4}, lo[0] & (m inside {3'h0, 3'h2}), lo[0] & (m == 3'h4) & go,
                !(m inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h6})};
    endfunction : dec

    // Code 001 with edge 10/11 fires on both edges; code 010 splits start and capture
    function automatic logic [15:0] pick(input logic [1:0] e, input logic [15:0] r, f, i,
                                         input logic [2:0] t, input logic cap);
        case (t)
            TCMS_TRIG_EDGE: return e[1] ? r + f : (e[0] ? r : f);
            TCMS_TRIG_BOTH: return ((e == TCMS_EDGE_HIGH) ^ cap) ? r : f;
            TCMS_TRIG_MASTER: return cap ? 16'h0 : i;
            default: return 16'h0;
        endcase
    endfunction : pick

    initial
    begin
        logic [7:0]  q;
        logic [7:0]  hi[2];
        logic [7:0]  lo[2];
        logic [15:0] rf;
        void'($urandom(32'h7eceae87));
        repeat (16) @(posedge mclk);
        chk_reg("waitrequest in reset", 8'h1, {7'h0, wait_r});
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b0, TCMS_ADDR_CH0_LOW + 20'(r), 8'h0, q);
            chk_reg("reset value", TCMS_MODE_RESET, q);
        end
        cnting <= 2'($urandom);
        sw_st <= 2'($urandom);
        // Assigned bits set with legal codes only; channel 0 bit 3 written to see it ignored
        for (int r = 0; r < 4; r++)
            bus(1'b1, TCMS_ADDR_CH0_LOW + 20'(r), (mk[r] & 8'hfc) | 8'h08, q);
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b0, TCMS_ADDR_CH0_LOW + 20'(r), 8'h0, q);
            chk_reg("masked bits", mk[r] & 8'hfc, q);
        end
        bus(1'b1, 20'hf0196, 8'h5a, q);
        bus(1'b0, 20'hf0196, 8'h0, q);
        chk_reg("unmapped", 8'h0, q);
        bus(1'b0, TCMS_ADDR_STATUS, 8'h0, q);
        chk_reg("status", 8'h0, q);
        run <= 2'($urandom_range(1, 3));
        bus(1'b0, TCMS_ADDR_RUNNING, 8'h0, q);
        chk_reg("running", {6'h0, run}, q);
        run <= 2'h0;
        for (int i = 0; i < 16; i++)
        begin
            cnting <= 2'($urandom);
            sw_st <= 2'($urandom);
            for (int n = 0; n < 2; n++)
            begin
                hi[n] = {1'($urandom_range(1)), 2'h0, 1'($urandom_range(1)), 1'(n) & 1'($urandom_range(1)),
                         tt[(i / 4 + n) % 4]};
                lo[n] = {2'((i + n) % 4), 2'h0, 3'($urandom_range(7)), 1'($urandom_range(1))};
                if (lo[n][7:6] == TCMS_EDGE_HIGH && hi[n][2:0] != TCMS_TRIG_BOTH)
                    lo[n][6] = 1'b0;
                bus(1'b1, TCMS_ADDR_CH0_LOW + 20'(2 * n), lo[n], q);
                bus(1'b1, TCMS_ADDR_CH0_HIGH + 20'(2 * n), hi[n], q);
                bus(1'b0, TCMS_ADDR_CH0_HIGH + 20'(2 * n), 8'h0, q);
                chk_reg("mode high", hi[n] & mk[2 * n + 1], q);
                chk_reg("mode code", {5'h0, lo[n][3:1]}, {5'h0, md[3 * n +: 3]});
                chk_reg("decode", {4'h0, dec(lo[n], cnting[n] & sw_st[n])},
                        {4'h0, down[n], stirq[n], restart[n], bad[n]});
            end
            chk_reg("split", {7'h0, hi[1][3]}, {7'h0, split});
            // Clocks stop outside the window, so latency cannot skew counts
            win <= 1'b1;
            @(posedge mclk);
            clk_on <= 1'b1;
            pin_on <= 1'b1;
            repeat (200) @(posedge mclk);
            pin_on <= 1'b0;
            repeat (24) @(posedge mclk);
            clk_on <= 1'b0;
            repeat (8) @(posedge mclk);
            win <= 1'b0;
            @(negedge mclk);
            for (int n = 0; n < 2; n++)
            begin
                rf = hi[n][7] ? cnt[1] : cnt[0];
                chk_cnt("op clock", rf, cnt[7 + n]);
                chk_cnt("count clock", hi[n][4] ? (lo[n][7] ? cnt[3 + n] + cnt[5 + n] : (lo[n][6] ? cnt[3 + n]
                        : cnt[5 + n])) : rf, cnt[9 + n]);
                chk_cnt("start trig", pick(lo[n][7:6], cnt[3 + n], cnt[5 + n], cnt[2], hi[n][2:0], 1'b0),
                        cnt[11 + n]);
                chk_cnt("capture trig", pick(lo[n][7:6], cnt[3 + n], cnt[5 + n], cnt[2], hi[n][2:0], 1'b1),
                        cnt[13 + n]);
            end
            @(posedge mclk);
        end
        bus(1'b1, TCMS_ADDR_CH1_HIGH, 8'h9c, q);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, TCMS_ADDR_CH1_HIGH, 8'h0, q);
        chk_reg("mid-run reset", TCMS_MODE_RESET, q);
        chk_reg("mode after reset", 8'h0, {2'h0, md});
        print_verdict();
    end
endmodule : tcms_top_test
